// *** src_reset_ctrl.sv ***
// system reset controller: cause register, reset merge and clock start sequencing
`timescale 1ns/1ps
`include "src_regs.svh"

module src_reset_ctrl #(
  parameter int OSC_WAIT = `SRC_OSC_WAIT_CYC,
  parameter int WDT_HOLD = `SRC_WDT_HOLD_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // reset sources and main clock tick
  input wire logic RESET_PIN_B,
  input wire logic WDT_RESET_REQ,
  input wire logic LV_BELOW,
  input wire logic CLK_STOP_DET,
  input wire logic MAIN_CLK_TICK,
  // protected special-register port
  input wire logic [1:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_PROT_OK,
  input wire logic REG_BIT_WR,
  input wire logic [2:0] REG_BIT_SEL,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // system controls
  output logic SYS_RESET,
  output logic MAIN_OSC_EN,
  output logic INT_OSC_EN,
  output logic CPU_CLK_EN,
  output logic CPU_ON_INTOSC,
  output logic CLK_DIV8,
  output logic WDT_CLEAR,
  output logic PINS_HIZ,
  output logic LV_DET_RESET,
  output logic LV_INTERRUPT,
  output logic CLK_MON_EN,
  output logic [7:0] DEBUG_MODE_CTRL,
  output logic RAM_GUARD
);

  // ************************************
  // reset merge
  // ************************************
  logic pin_rst;
  logic lv_rst;
  logic wdt_rst;
  logic any_rst;
  src_pkg::seq_state_e st_q;
  src_pkg::seq_state_e st_d;
  logic lvsel_q;
  logic lvsel_d;
  logic clock_monitor_enable_q;
  logic clock_monitor_enable_d;
  logic [$clog2(WDT_HOLD+1)-1:0] wdt_cnt_q;
  logic [$clog2(WDT_HOLD+1)-1:0] wdt_cnt_d;

  assign pin_rst = ~RESET_PIN_B;
  assign lv_rst = LV_BELOW & lvsel_q;
  // an overflow during the wait means a dead crystal: switch clocks rather than reset
  assign wdt_rst = WDT_RESET_REQ & (st_q != src_pkg::ST_OSCWAIT);
  // asserting sources act in the same cycle; release passes the sequencer sync state
  assign any_rst = pin_rst | lv_rst | (wdt_cnt_q != '0) | wdt_rst | (CLK_STOP_DET & clock_monitor_enable_q);

  always_comb begin
    wdt_cnt_d = wdt_cnt_q;
    if (wdt_rst) begin
      wdt_cnt_d = WDT_HOLD[$bits(wdt_cnt_q)-1:0];
    end else if (wdt_cnt_q != '0) begin
      wdt_cnt_d = wdt_cnt_q - 1'b1;
    end
  end

  // ************************************
  // register file
  // ************************************
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  logic [7:0] wmask;
  logic [7:0] wval;
  logic [7:0] hw_set;
  logic wr_ok;

  assign wr_ok = REG_WR & REG_PROT_OK;

  always_comb begin
    // byte write touches all bits, bit write only the selected one
    wmask = REG_BIT_WR ? (8'h01 << REG_BIT_SEL) : 8'hFF;
    wval = REG_BIT_WR ? {8{REG_WDATA[0]}} : REG_WDATA;
    hw_set = 8'h00;
    hw_set[`SRC_BIT_WDRF] = WDT_RESET_REQ;
    hw_set[`SRC_BIT_LVRF] = lv_rst;
    hw_set[`SRC_BIT_CMRF] = CLK_STOP_DET & clock_monitor_enable_q;
    cause_d = cause_q;
    lvsel_d = lvsel_q;
    clock_monitor_enable_d = clock_monitor_enable_q;
    if (wr_ok && REG_ADDR == `SRC_ADDR_CAUSE) begin
      cause_d = cause_q & ~(wmask & ~wval);
    end
    if (wr_ok && REG_ADDR == `SRC_ADDR_LVCTL && wmask[`SRC_BIT_LVSEL]) begin
      lvsel_d = wval[`SRC_BIT_LVSEL];
    end
    if (wr_ok && REG_ADDR == `SRC_ADDR_CLMON && wmask[`SRC_BIT_CLOCK_MONITOR_ENABLE] && wval[`SRC_BIT_CLOCK_MONITOR_ENABLE]) begin
      clock_monitor_enable_d = 1'b1; // once set, only a reset clears it
    end
    cause_d = (cause_d | hw_set) & `SRC_CAUSE_MASK;
    if (hw_set[`SRC_BIT_CMRF]) begin
      clock_monitor_enable_d = 1'b0;
    end
    if (pin_rst) begin
      cause_d = `SRC_CAUSE_RST;
      clock_monitor_enable_d = 1'b0;
      lvsel_d = 1'b0;
    end else if (wdt_rst || hw_set[`SRC_BIT_CMRF]) begin
      clock_monitor_enable_d = 1'b0;
      lvsel_d = 1'b0;
    end
    // a voltage reset keeps the detector settings as they are
    if (lv_rst) begin
      lvsel_d = lvsel_q;
    end
  end

  // ************************************
  // sequencer
  // ************************************
  logic [16:0] osc_cnt_q;
  logic [16:0] osc_cnt_d;
  logic [7:0] dbg_q;
  logic [7:0] dbg_d;
  logic wdt_ovf_early;

  // watchdog reset request seen during the wait is the emergency trigger
  assign wdt_ovf_early = WDT_RESET_REQ & (st_q == src_pkg::ST_OSCWAIT);

  always_comb begin
    st_d = st_q;
    osc_cnt_d = osc_cnt_q;
    dbg_d = dbg_q;
    if (pin_rst) begin
      dbg_d = `SRC_DEBUG_PIN_RST;
    end
    case (st_q)
      src_pkg::ST_RESET: begin
        osc_cnt_d = '0;
        if (!any_rst) begin
          st_d = src_pkg::ST_SYNC;
        end
      end
      src_pkg::ST_SYNC: begin
        st_d = src_pkg::ST_OSCWAIT;
      end
      src_pkg::ST_OSCWAIT: begin
        if (MAIN_CLK_TICK) begin
          osc_cnt_d = osc_cnt_q + 17'h00001;
        end
        if (osc_cnt_q >= OSC_WAIT[16:0] - 17'h00001 && MAIN_CLK_TICK) begin
          st_d = src_pkg::ST_RUN_MAIN;
        end
      end
      src_pkg::ST_RUN_MAIN: begin
        st_d = src_pkg::ST_RUN_MAIN;
      end
      src_pkg::ST_RUN_INTOSC: begin
        st_d = src_pkg::ST_RUN_INTOSC;
      end
      default: begin
        st_d = src_pkg::ST_RESET;
      end
    endcase
    // any real reset source outranks the emergency switch
    if (any_rst) begin
      st_d = src_pkg::ST_RESET;
    end else if (wdt_ovf_early) begin
      st_d = src_pkg::ST_RUN_INTOSC;
    end
  end

  // ************************************
  // output next values
  // ************************************
  logic [7:0] rdata_d;
  logic sys_reset_d;
  logic main_osc_d;
  logic int_osc_d;
  logic cpu_clk_d;
  logic cpu_intosc_d;
  logic div8_d;
  logic wdt_clear_d;
  logic pins_hiz_d;
  logic lv_det_rst_d;
  logic lv_irq_d;
  logic clk_mon_d;
  logic ram_guard_d;

  always_comb begin
    case (REG_ADDR)
      `SRC_ADDR_CAUSE: rdata_d = cause_q;
      `SRC_ADDR_CLKSTAT: rdata_d = {7'h00, st_q == src_pkg::ST_RUN_INTOSC};
      `SRC_ADDR_LVCTL: rdata_d = {6'h00, lvsel_q, LV_BELOW};
      default: rdata_d = {7'h00, clock_monitor_enable_q};
    endcase
    sys_reset_d = any_rst || st_d == src_pkg::ST_RESET;
    main_osc_d = st_d != src_pkg::ST_RESET && st_d != src_pkg::ST_RUN_INTOSC;
    int_osc_d = st_d != src_pkg::ST_RESET;
    cpu_clk_d = st_d == src_pkg::ST_RUN_MAIN || st_d == src_pkg::ST_RUN_INTOSC;
    cpu_intosc_d = st_d == src_pkg::ST_RUN_INTOSC;
    // divider leaves reset at one eighth; only software would change it
    div8_d = (st_d == src_pkg::ST_RESET) ? 1'b1 : CLK_DIV8;
    wdt_clear_d = st_d == src_pkg::ST_RESET;
    pins_hiz_d = st_d == src_pkg::ST_RESET;
    // the detector is only cleared by resets it did not cause
    lv_det_rst_d = any_rst & ~lv_rst;
    lv_irq_d = LV_BELOW & ~lvsel_q;
    clk_mon_d = clock_monitor_enable_d & (st_d == src_pkg::ST_RUN_MAIN);
    // RAM is retained; only a reset arriving while the CPU clock is enabled is flagged
    ram_guard_d = any_rst & CPU_CLK_EN;
  end

  // ************************************
  // registers
  // ************************************
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cause_q <= `SRC_CAUSE_RST;
      lvsel_q <= 1'b0;
      clock_monitor_enable_q <= 1'b0;
      wdt_cnt_q <= '0;
      st_q <= src_pkg::ST_RESET;
      osc_cnt_q <= 17'h00000;
      dbg_q <= `SRC_DEBUG_PIN_RST;
      REG_RDATA <= 8'h00;
      SYS_RESET <= 1'b1;
      MAIN_OSC_EN <= 1'b0;
      INT_OSC_EN <= 1'b0;
      CPU_CLK_EN <= 1'b0;
      CPU_ON_INTOSC <= 1'b0;
      CLK_DIV8 <= 1'b1;
      WDT_CLEAR <= 1'b1;
      PINS_HIZ <= 1'b1;
      LV_DET_RESET <= 1'b1;
      LV_INTERRUPT <= 1'b0;
      CLK_MON_EN <= 1'b0;
      DEBUG_MODE_CTRL <= `SRC_DEBUG_PIN_RST;
      RAM_GUARD <= 1'b0;
    end else if (CLK_EN) begin
      cause_q <= cause_d;
      lvsel_q <= lvsel_d;
      clock_monitor_enable_q <= clock_monitor_enable_d;
      wdt_cnt_q <= wdt_cnt_d;
      st_q <= st_d;
      osc_cnt_q <= osc_cnt_d;
      dbg_q <= dbg_d;
      REG_RDATA <= rdata_d;
      SYS_RESET <= sys_reset_d;
      MAIN_OSC_EN <= main_osc_d;
      INT_OSC_EN <= int_osc_d;
      CPU_CLK_EN <= cpu_clk_d;
      CPU_ON_INTOSC <= cpu_intosc_d;
      CLK_DIV8 <= div8_d;
      WDT_CLEAR <= wdt_clear_d;
      PINS_HIZ <= pins_hiz_d;
      LV_DET_RESET <= lv_det_rst_d;
      LV_INTERRUPT <= lv_irq_d;
      CLK_MON_EN <= clk_mon_d;
      DEBUG_MODE_CTRL <= dbg_d;
      RAM_GUARD <= ram_guard_d;
    end
  end

endmodule

// *** src_regs.svh ***
// register offsets, field positions, reset values and timing counts of the reset controller
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH
// register index on the special-register port
`define SRC_ADDR_CAUSE 2'h0
`define SRC_ADDR_CLKSTAT 2'h1
`define SRC_ADDR_LVCTL 2'h2
`define SRC_ADDR_CLMON 2'h3
// reset cause register fields
`define SRC_BIT_LVRF 0
`define SRC_BIT_CMRF 1
`define SRC_BIT_WDRF 4
`define SRC_CAUSE_RST 8'h00
`define SRC_CAUSE_MASK 8'h13
// other fields
`define SRC_BIT_CPUCLK 0
`define SRC_BIT_LVSEL 1
`define SRC_BIT_CLOCK_MONITOR_ENABLE 0
`define SRC_DEBUG_PIN_RST 8'h01
// main clock stabilisation, in main clock cycles (2^16)
`define SRC_OSC_WAIT_CYC 17'h10000
// watchdog reset hold (fixed delay), clock cycles
`define SRC_WDT_HOLD_NS 1000
`define SRC_CLK_NS 20
`define SRC_WDT_HOLD_CYC ((`SRC_WDT_HOLD_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS)
`endif

// *** src_pkg.sv ***
// types of the system reset controller
package src_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_SYNC,
    ST_OSCWAIT,
    ST_RUN_MAIN,
    ST_RUN_INTOSC
  } seq_state_e;
endpackage

// *** src_osc.sv ***
// main oscillator model feeding the tick input
`timescale 1ns/1ps
module src_osc (
  // clock and control
  input wire logic clk,
  input wire logic osc_en,
  input wire logic slow,
  // tick out
  output logic tick
);
  logic [1:0] div_q = 2'h0;
  // a stopped crystal gives no edges, so no ticks
  always @(posedge clk) begin
    div_q <= osc_en ? div_q + 2'h1 : 2'h0;
    tick <= osc_en && (!slow || div_q == 2'h3);
  end
endmodule

// *** src_chk.sv ***
// assertion checker of the reset controller ports
`timescale 1ns/1ps
module src_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // watched
  input wire logic RESET_PIN_B,
  input wire logic [1:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic SYS_RESET,
  input wire logic MAIN_OSC_EN,
  input wire logic INT_OSC_EN,
  input wire logic CPU_CLK_EN,
  input wire logic CPU_ON_INTOSC,
  input wire logic CLK_DIV8,
  input wire logic WDT_CLEAR,
  input wire logic PINS_HIZ,
  input wire logic [7:0] DEBUG_MODE_CTRL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  pin_hold_a: assert property (CLK_EN && !RESET_PIN_B |=> SYS_RESET)
    else $error("pin reset not held");
  cause_clr_a: assert property (CLK_EN && !RESET_PIN_B ##1 CLK_EN && REG_ADDR == 2'h0
    |=> REG_RDATA == 8'h00) else $error("cause not cleared");
  hiz_wdt_a: assert property (SYS_RESET |-> PINS_HIZ && WDT_CLEAR)
    else $error("pins or watchdog free in reset");
  osc_stop_a: assert property (SYS_RESET |-> !MAIN_OSC_EN && !INT_OSC_EN)
    else $error("oscillator on in reset");
  cpu_gate_a: assert property (CPU_CLK_EN |-> !SYS_RESET && !WDT_CLEAR)
    else $error("cpu clock in reset");
  div_a: assert property ($rose(CPU_CLK_EN) |-> CLK_DIV8)
    else $error("divider not eighth");
  dbg_a: assert property (CLK_EN && !RESET_PIN_B |=> DEBUG_MODE_CTRL == 8'h01)
    else $error("debug register not loaded");
  emerg_a: assert property ($rose(CPU_ON_INTOSC) |-> CPU_CLK_EN && !MAIN_OSC_EN)
    else $error("emergency mode wrong");
  cover property ($rose(CPU_ON_INTOSC));
  cover property ($rose(CPU_CLK_EN));
  cover property ($fell(SYS_RESET));
endmodule
bind src_reset_ctrl src_chk i_src_chk (.*);

// *** tb.sv ***
// self-checking bench of the reset controller
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0, rst_b = 1'h0, pin_b = 1'h1, wdr = 1'h0, lvb = 1'h0, slow = 1'h0;
  logic wr = 1'h0, prot = 1'h0, bw = 1'h0, rv = 1'h0, rv2 = 1'h0, tick;
  logic cen = 1'h1, cs = 1'h0;
  logic [1:0] addr = 2'h0;
  logic [2:0] sel = 3'h0;
  logic [7:0] wd = 8'h00, rd, dbg;
  logic sr, mo, io, ce, ci, d8, hz, lr, li;
  logic [7:0] eq[$];
  int failures = 0, checks_done = 0, cyc = 0;
  always #10 clk = ~clk;
  src_osc i_src_osc (.clk(clk), .osc_en(mo), .slow(slow), .tick(tick));
  src_reset_ctrl #(.OSC_WAIT(16), .WDT_HOLD(4)) i_src_reset_ctrl (.CLK(clk),
    .RST_B(rst_b), .CLK_EN(cen), .RESET_PIN_B(pin_b), .WDT_RESET_REQ(wdr),
    .LV_BELOW(lvb), .CLK_STOP_DET(cs), .MAIN_CLK_TICK(tick), .REG_ADDR(addr),
    .REG_WR(wr), .REG_PROT_OK(prot), .REG_BIT_WR(bw), .REG_BIT_SEL(sel), .REG_WDATA(wd),
    .REG_RDATA(rd), .SYS_RESET(sr), .MAIN_OSC_EN(mo), .INT_OSC_EN(io), .CPU_CLK_EN(ce),
    .CPU_ON_INTOSC(ci), .CLK_DIV8(d8), .WDT_CLEAR(), .PINS_HIZ(hz), .LV_DET_RESET(lr),
    .LV_INTERRUPT(li), .CLK_MON_EN(), .DEBUG_MODE_CTRL(dbg), .RAM_GUARD());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rdq(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rv <= 1'h1;
    eq.push_back(e);
    @(posedge clk);
    rv <= 1'h0;
  endtask
  task automatic wrt(input logic [1:0] a, input logic [7:0] d, input logic b, input logic p);
    @(posedge clk);
    addr <= a;
    wd <= d;
    bw <= b;
    sel <= 3'h0;
    prot <= p;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // bounded wait: a stuck sequencer shows up as a failed compare
  task automatic wrun();
    int n;
    n = 0;
    while (ce !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
  endtask
  always @(posedge clk) rv2 <= rv;
  always @(negedge clk) if (rv2) chk(rd, eq.pop_front());
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    void'($urandom(85));
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    pin_b <= 1'h0;
    rdq(2'h0, 8'h00);
    @(negedge clk);
    chk({5'h0, sr, hz, mo | io}, 8'h06);
    chk(dbg, 8'h01);
    @(posedge clk);
    pin_b <= 1'h1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({7'h0, ce}, 8'h00);
    wrun();
    chk({5'h0, ce, d8, ci}, 8'h06);
    // with the clock enable low even a pin reset must leave all state frozen
    @(posedge clk);
    cen <= 1'h0;
    pin_b <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({6'h0, sr, ce}, 8'h01);
    @(posedge clk);
    pin_b <= 1'h1;
    cen <= 1'h1;
    wrt(2'h2, 8'h02, 1'h0, 1'h1);
    rdq(2'h2, 8'h02);
    lvb <= 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({6'h0, sr, lr}, 8'h02);
    @(posedge clk);
    lvb <= 1'h0;
    wrun();
    rdq(2'h0, 8'h01);
    wrt(2'h0, 8'($urandom), 1'h0, 1'h0);
    rdq(2'h0, 8'h01);
    wrt(2'h0, 8'hFF, 1'h0, 1'h1);
    rdq(2'h0, 8'h01);
    wrt(2'h0, 8'h00, 1'h1, 1'h1);
    rdq(2'h0, 8'h00);
    slow <= 1'h1;
    pin_b <= 1'h0;
    repeat (2) @(posedge clk);
    pin_b <= 1'h1;
    repeat (3 + $urandom % 4) @(posedge clk);
    wdr <= 1'h1;
    @(posedge clk);
    wdr <= 1'h0;
    @(negedge clk);
    chk({5'h0, ci, ce, mo}, 8'h06);
    rdq(2'h1, 8'h01);
    rdq(2'h0, 8'h10);
    wdr <= 1'h1;
    @(posedge clk);
    wdr <= 1'h0;
    @(negedge clk);
    chk({6'h0, sr, mo}, 8'h02);
    wrun();
    chk({7'h0, ce}, 8'h01);
    @(posedge clk);
    lvb <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({6'h0, sr, li}, 8'h01);
    @(posedge clk);
    lvb <= 1'h0;
    wrt(2'h3, 8'h01, 1'h0, 1'h1);
    rdq(2'h3, 8'h01);
    cs <= 1'h1;
    @(posedge clk);
    cs <= 1'h0;
    @(negedge clk);
    chk({7'h0, sr}, 8'h01);
    wrun();
    rdq(2'h0, 8'h12);
    rdq(2'h3, 8'h00);
    final_report();
  end
endmodule
